// ==== logic/scs_cfg_regs.sv ====
// Configuration register bank with its serial target port
//
// Operation
// R1: Mode register bit 0 is the configuration flag, reset 1, 0 is normal.
// R2: Configuration flag takes effect only if serial mode was found at reset.
// R3: Host writes 1 to enter configuration mode, 0 to leave it.
// R4: Reserved upper bits of mode and lift registers take fixed values at reset.
// R5: Host rewrites reserved bits with the values it read back.
// R6: Lift field bits 3-0 start from the decoded boost strap level.
// R7: Boost strap 0 gives 0x0, 1 and 2 give 0x2, 3 gives 0x6.
// R8: Any written lift value 0x0 to 0xF is accepted.
// R9: Whole sensitivity register starts from the decoded sensitivity strap.
// R10: Sensitivity strap low gives 0x0, medium 0x33, high 0x66.
// R11: Any written sensitivity value 0x00 to 0xFF is accepted.
// R12: Writes to unlisted offsets change nothing.
// R13: Registers are reached at seven-bit serial target address 0x2C.
// R14: Serial port is enabled only if both lines are high after reset.
// R15: Host sets configuration flag before changes and clears it afterwards.
// R16: Boost strap is latched only at reset and ignored afterwards.
`timescale 1ns/1ps
`default_nettype none

module scs_cfg_regs (
    input  wire logic        mclk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        ce_in,
    input  wire logic        chip_enable_n_in,
    input  wire logic [1:0]  boost_level_in,
    input  wire logic [1:0]  sens_level_in,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_out,
    output logic             i2c_enabled_out,
    output logic             config_mode_out,
    output logic [3:0]       static_lift_field_out,
    output logic [7:0]       receive_sensitivity_out
);
    import scs_pkg::*;
`include "scs_consts.svh"

    logic        rst;
    scs_bus_ev_t ev;
    scs_strap_t  strap;
    scs_core_t   q;
    scs_core_t   d;

    // Shutdown pin low behaves exactly like a system reset
    assign rst = sys_rst_in | ~chip_enable_n_in;

    scs_i2c_phy i_scs_i2c_phy (
        .mclk_in (mclk_in),
        .rst_in  (rst),
        .ce_in   (ce_in),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .ev_out  (ev)
    );

    scs_strap_cap i_scs_strap_cap (
        .mclk_in        (mclk_in),
        .rst_in         (rst),
        .ce_in          (ce_in),
        .boost_level_in (boost_level_in),
        .sens_level_in  (sens_level_in),
        .scl_in         (scl_in),
        .sda_in         (sda_in),
        .strap_out      (strap)
    );

    function automatic logic is_write_phase(input scs_state_t s);
        return (s == ST_ADDR) || (s == ST_REG) || (s == ST_WDATA);
    endfunction

    always_comb begin
        d = q;

        if (strap.load) begin
            // Strap values land once, one cycle after the capture
            d.regs.lift = {`SCS_LIFT_RSV_RST, strap.lift}; // R6 R16
            d.regs.sens = strap.sens; // R9
        end else if (!strap.i2c_en) begin
            // Port stays dead without serial mode, so the flag stays reset
            d.st = ST_IDLE; // R14
            d.oe = 1'b0;
        end else if (ev.start) begin
            // A repeated start keeps the pointer for a following read
            d.st = ST_ADDR;
            d.bit_n = 4'h0;
            d.oe = 1'b0;
        end else if (ev.stop) begin
            d.st = ST_IDLE;
            d.bit_n = 4'h0;
            d.oe = 1'b0;
        end else if (q.st == ST_IDLE || q.st == ST_HOLD) begin
            d.oe = 1'b0;
        end else if (ev.scl_rise) begin
            if (q.bit_n != `SCS_BIT_LAST) begin
                d.bit_n = q.bit_n + 4'h1;
                if (is_write_phase(q.st)) begin
                    d.shf = {q.shf[6:0], ev.sda};
                end
            end else begin
                d.bit_n = 4'h0;
                unique case (q.st)
                    ST_ADDR: begin
                        if (q.shf[0]) begin
                            d.st = ST_RDATA;
                            d.shf = scs_reg_read(q.regs, q.ptr);
                            d.ptr = q.ptr + 8'h01;
                        end else begin
                            d.st = ST_REG;
                        end
                    end
                    ST_REG: begin
                        d.ptr = q.shf;
                        d.st = ST_WDATA;
                    end
                    ST_WDATA: begin
                        // Full byte stored as written: reserved bits are the host's to preserve
                        d.regs = scs_reg_write(q.regs, q.ptr, q.shf); // R3 R8 R11 R12
                        d.ptr = q.ptr + 8'h01;
                    end
                    ST_RDATA: begin
                        if (ev.sda) begin
                            // Controller refused the byte: the read is over
                            d.st = ST_HOLD;
                        end else begin
                            d.shf = scs_reg_read(q.regs, q.ptr);
                            d.ptr = q.ptr + 8'h01;
                        end
                    end
                    default: d.st = ST_HOLD;
                endcase
            end
        end else if (ev.scl_fall) begin
            if (q.bit_n != `SCS_BIT_LAST) begin
                if (q.st == ST_RDATA) begin
                    d.oe = ~q.shf[7];
                    d.shf = {q.shf[6:0], 1'b0};
                end else begin
                    d.oe = 1'b0;
                end
            end else if (q.st == ST_RDATA) begin
                d.oe = 1'b0;
            end else if (q.st == ST_ADDR && q.shf[7:1] != `SCS_I2C_ADDR) begin
                // Other targets' traffic is left alone until the next frame
                d.st = ST_HOLD; // R13
                d.oe = 1'b0;
            end else begin
                d.oe = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst) begin
            q.st <= ST_IDLE;
            q.bit_n <= 4'h0;
            q.shf <= 8'h00;
            q.ptr <= 8'h00;
            q.oe <= 1'b0;
            q.regs.mode <= {`SCS_MODE_RSV_RST, `SCS_MODE_FLAG_RST}; // R1 R4
            q.regs.lift <= {`SCS_LIFT_RSV_RST, `SCS_LIFT_RST}; // R4
            q.regs.sens <= `SCS_SENS_RST;
        end else if (ce_in) begin
            q <= d;
        end
    end

    // Open drain: the line is only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe_out = q.oe;
    assign i2c_enabled_out = strap.i2c_en;
    assign config_mode_out = q.regs.mode[`SCS_CFG_BIT] & strap.i2c_en; // R1 R2
    assign static_lift_field_out = q.regs.lift[3:0];
    assign receive_sensitivity_out = q.regs.sens;

endmodule

`default_nettype wire

// ==== logic/scs_consts.svh ====
// Constants of the signal conditioner configuration register bank
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

`define SCS_I2C_ADDR      7'h2C
`define SCS_OFS_MODE      8'h03
`define SCS_OFS_LIFT      8'h0E
`define SCS_OFS_SENS      8'h25
`define SCS_CFG_BIT       0
`define SCS_MODE_RSV_RST  7'h00
`define SCS_MODE_FLAG_RST 1'b1
`define SCS_LIFT_RSV_RST  4'h0
`define SCS_LIFT_RST      4'h0
`define SCS_SENS_RST      8'h00
`define SCS_LIFT_LVL0     4'h0
`define SCS_LIFT_LVL12    4'h2
`define SCS_LIFT_LVL3     4'h6
`define SCS_SENS_LOW      8'h00
`define SCS_SENS_MID      8'h33
`define SCS_SENS_HIGH     8'h66
`define SCS_SENS_CODE_LOW 2'h0
`define SCS_SENS_CODE_MID 2'h1
`define SCS_SENS_CODE_HI  2'h2
`define SCS_BIT_LAST      4'h8
`define SCS_READ_EMPTY    8'h00

`endif

// ==== logic/scs_pkg.sv ====
// Types and helper functions of the configuration register bank
`default_nettype none

package scs_pkg;
`include "scs_consts.svh"

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_REG,
        ST_WDATA,
        ST_RDATA,
        ST_HOLD
    } scs_state_t;

    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
        logic sda;
    } scs_bus_ev_t;

    typedef struct packed {
        logic       load;
        logic       i2c_en;
        logic [3:0] lift;
        logic [7:0] sens;
    } scs_strap_t;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] lift;
        logic [7:0] sens;
    } scs_regs_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } scs_phy_t;

    typedef struct packed {
        logic       pend;
        scs_strap_t cap;
    } scs_strap_st_t;

    typedef struct packed {
        scs_state_t st;
        logic [3:0] bit_n;
        logic [7:0] shf;
        logic [7:0] ptr;
        logic       oe;
        scs_regs_t  regs;
    } scs_core_t;

    function automatic logic [3:0] scs_lift_decode(input logic [1:0] lvl);
        logic [3:0] v;
        unique case (lvl)
            2'h0:    v = `SCS_LIFT_LVL0;
            2'h1:    v = `SCS_LIFT_LVL12;
            2'h2:    v = `SCS_LIFT_LVL12;
            2'h3:    v = `SCS_LIFT_LVL3;
        endcase
        return v;
    endfunction

    // Code 3 has no strap meaning; it is taken as medium, the open-pin level
    function automatic logic [7:0] scs_sens_decode(input logic [1:0] lvl);
        logic [7:0] v;
        unique case (lvl)
            `SCS_SENS_CODE_LOW: v = `SCS_SENS_LOW;
            `SCS_SENS_CODE_HI:  v = `SCS_SENS_HIGH;
            default:            v = `SCS_SENS_MID;
        endcase
        return v;
    endfunction

    function automatic logic [7:0] scs_reg_read(input scs_regs_t r, input logic [7:0] ofs);
        logic [7:0] v;
        unique case (ofs)
            `SCS_OFS_MODE: v = r.mode;
            `SCS_OFS_LIFT: v = r.lift;
            `SCS_OFS_SENS: v = r.sens;
            default:       v = `SCS_READ_EMPTY;
        endcase
        return v;
    endfunction

    function automatic scs_regs_t scs_reg_write(input scs_regs_t r, input logic [7:0] ofs,
                                                input logic [7:0] data);
        scs_regs_t v;
        v = r;
        unique case (ofs)
            `SCS_OFS_MODE: v.mode = data;
            `SCS_OFS_LIFT: v.lift = data;
            `SCS_OFS_SENS: v.sens = data;
            default:       v = r;
        endcase
        return v;
    endfunction

endpackage

`default_nettype wire

// ==== logic/scs_i2c_phy.sv ====
// Serial line edge, start and stop detection
`timescale 1ns/1ps
`default_nettype none

module scs_i2c_phy (
    input  wire logic              mclk_in,
    input  wire logic              rst_in,
    input  wire logic              ce_in,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output scs_pkg::scs_bus_ev_t   ev_out
);
    import scs_pkg::*;

    scs_phy_t q;
    scs_phy_t d;

    always_comb begin
        d = q;
        d.scl = scl_in;
        d.sda = sda_in;
        ev_out.scl_rise = scl_in & ~q.scl;
        ev_out.scl_fall = ~scl_in & q.scl;
        // Data moving while the clock stays high marks a frame boundary
        ev_out.start = scl_in & q.scl & q.sda & ~sda_in;
        ev_out.stop = scl_in & q.scl & ~q.sda & sda_in;
        ev_out.sda = sda_in;
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            q <= '{scl: 1'b1, sda: 1'b1};
        end else if (ce_in) begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

// ==== logic/scs_strap_cap.sv ====
// Capture and decode of strap pins once after reset release
`timescale 1ns/1ps
`default_nettype none

module scs_strap_cap (
    input  wire logic             mclk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic [1:0]       boost_level_in,
    input  wire logic [1:0]       sens_level_in,
    input  wire logic             scl_in,
    input  wire logic             sda_in,
    output scs_pkg::scs_strap_t   strap_out
);
    import scs_pkg::*;

    scs_strap_st_t q;
    scs_strap_st_t d;

    always_comb begin
        d = q;
        d.cap.load = 1'b0;
        // Pins are looked at exactly once; later changes need a new reset
        if (q.pend) begin
            d.pend = 1'b0;
            d.cap.load = 1'b1;
            d.cap.lift = scs_lift_decode(boost_level_in); // R6 R7 R16
            d.cap.sens = scs_sens_decode(sens_level_in); // R9 R10
            d.cap.i2c_en = scl_in & sda_in; // R14
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            q <= '{pend: 1'b1,
                   cap: '{load: 1'b0, i2c_en: 1'b0, lift: `SCS_LIFT_RST, sens: `SCS_SENS_RST}};
        end else if (ce_in) begin
            q <= d;
        end
    end

    assign strap_out = q.cap;

endmodule

`default_nettype wire

// ==== tb/scs_cfg_regs_checker.sv ====
// Port-level assertions of the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module scs_cfg_regs_checker (
    input wire logic       mclk_in,
    input wire logic       sys_rst_in,
    input wire logic       ce_in,
    input wire logic       chip_enable_n_in,
    input wire logic [1:0] boost_level_in,
    input wire logic [1:0] sens_level_in,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_out,
    input wire logic       i2c_enabled_out,
    input wire logic       config_mode_out,
    input wire logic [3:0] static_lift_field_out,
    input wire logic [7:0] receive_sensitivity_out
);
    wire logic       rst = sys_rst_in | ~chip_enable_n_in;
    wire logic [3:0] lift_x = (boost_level_in == 2'h0) ? 4'h0 : (boost_level_in == 2'h3) ? 4'h6 : 4'h2;
    wire logic [7:0] sens_x = (sens_level_in == 2'h0) ? 8'h00 : (sens_level_in == 2'h2) ? 8'h66 : 8'h33;
    logic [2:0]      ago_q;

    // Cycles since release; by count 4 the strap loads have surely landed
    always_ff @(posedge mclk_in) begin
        if (rst) begin
            ago_q <= 3'h0;
        end else if (ago_q != 3'h7) begin
            ago_q <= ago_q + 3'h1;
        end
    end

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst);
    sequence s_release;
        $fell(rst) && ce_in;
    endsequence

    chk_rst_clear: assert property ($fell(rst) |-> !sda_oe_out && !config_mode_out &&
        static_lift_field_out == 4'h0) else $error("reset left outputs set");
    chk_en_capture: assert property (s_release |=> i2c_enabled_out == $past(scl_in && sda_in))
        else $error("serial enable not taken from lines");
    chk_en_stable: assert property (ago_q == 3'h7 |-> $stable(i2c_enabled_out))
        else $error("serial enable changed after capture");
    chk_lift_strap: assert property (ago_q == 3'h4 |-> static_lift_field_out == lift_x)
        else $error("lift field not from strap");
    chk_sens_strap: assert property (ago_q == 3'h4 |-> receive_sensitivity_out == sens_x)
        else $error("sensitivity not from strap");
    chk_flag_reset: assert property (ago_q == 3'h4 |-> config_mode_out == i2c_enabled_out)
        else $error("mode flag reset wrong");
    chk_flag_gate: assert property (config_mode_out |-> i2c_enabled_out)
        else $error("config mode without serial mode");
    // Once settled, the flag only moves by a write, which commits on a clock-high sample
    chk_flag_commit: assert property (ago_q == 3'h7 && $changed(config_mode_out) |-> scl_in)
        else $error("mode flag moved outside a write");
    chk_port_dead: assert property (sda_oe_out |-> i2c_enabled_out && !sda_out)
        else $error("data pulled while port dead");
    chk_ack_start: assert property ($rose(sda_oe_out) |-> !scl_in)
        else $error("data pull began with clock high");
    chk_ack_end: assert property ($fell(sda_oe_out) |-> !scl_in && !$past(scl_in))
        else $error("data pull ended with clock high");
endmodule
bind scs_cfg_regs scs_cfg_regs_checker i_chk (.*);
`default_nettype wire

// ==== tb/scs_i2c_host.sv ====
// Behavioural serial bus host for the register bank's target port
`timescale 1ns/1ps
`default_nettype none
module scs_i2c_host (
    input  wire logic mclk_in,
    input  wire logic sda_in,
    output var logic  scl_out,
    output var logic  sda_out
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    // Data moves one clock after the clock line, so no edge looks like a start
    task automatic ph(input logic c, input logic d);
        @(posedge mclk_in);
        scl_out <= c;
        @(posedge mclk_in);
        sda_out <= d;
        repeat (2) @(posedge mclk_in);
    endtask

    task automatic xb(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            ph(1'b0, tx[i]);
            ph(1'b1, tx[i]);
            rx[i] = sda_in;
        end
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ack = ~sda_in;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic       k1, k2, k3;
        ph(1'b1, 1'b0);
        xb({a, 1'b0}, r, k1);
        xb(o, r, k2);
        xb(d, r, k3);
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b1);
        ok = k1 & k2 & k3;
    endtask

    // Pointer write, repeated start, one byte read ended by a refusal
    task automatic rd(input logic [6:0] a, input logic [7:0] o, output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic       k1, k2, k3, k4;
        ph(1'b1, 1'b0);
        xb({a, 1'b0}, r, k1);
        xb(o, r, k2);
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
        xb({a, 1'b1}, r, k3);
        xb(8'hFF, d, k4);
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b1);
        ok = k1 & k2 & k3;
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_scs_cfg_regs.sv ====
// Self-checking bench of the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb_scs_cfg_regs;
    import scs_pkg::*;
    logic       mclk_in = 1'b0;
    logic       sys_rst_in = 1'b1;
    logic       ce_in = 1'b1;
    logic       chip_enable_n_in = 1'b1;
    logic [1:0] boost_level_in = 2'h1;
    logic [1:0] sens_level_in = 2'h1;
    logic       hold_lo = 1'b0;
    logic       scl_in, sda_h, sda_out, sda_oe_out, i2c_enabled_out, config_mode_out, ok;
    logic [3:0] static_lift_field_out;
    logic [7:0] receive_sensitivity_out, v;
    wire logic  sda_in = sda_h & ~sda_oe_out & ~hold_lo;
    wire logic [7:0] lift8 = {4'h0, static_lift_field_out};
    wire logic [7:0] st8 = {6'h0, i2c_enabled_out, config_mode_out};
    int         errors = 0;
    int         compares = 0;

    always #12.5 mclk_in = ~mclk_in;

    scs_cfg_regs i_scs_cfg_regs (.*);
    scs_i2c_host i_scs_i2c_host (.mclk_in(mclk_in), .sda_in(sda_in), .scl_out(scl_in), .sda_out(sda_h));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        #1;
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        if (errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic w(input logic [7:0] o, input logic [7:0] d);
        i_scs_i2c_host.wr(7'h2C, o, d, ok);
    endtask

    task automatic r(input logic [7:0] o);
        i_scs_i2c_host.rd(7'h2C, o, v, ok);
    endtask

    // Data line held low at release leaves the serial port dead until the next reset
    task automatic do_rst(input logic [1:0] b, input logic [1:0] s, input logic pin, input logic lines);
        @(posedge mclk_in);
        boost_level_in <= b;
        sens_level_in <= s;
        hold_lo <= ~lines;
        if (pin) chip_enable_n_in <= 1'b0;
        else sys_rst_in <= 1'b1;
        repeat (16) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        chip_enable_n_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        hold_lo <= 1'b0;
        repeat (4) @(posedge mclk_in);
    endtask

    task automatic t_straps();
        logic [7:0] lx [4] = '{8'h00, 8'h02, 8'h02, 8'h06};
        logic [7:0] sx [4] = '{8'h33, 8'h66, 8'h33, 8'h00};
        for (int i = 0; i < 4; i++) begin
            do_rst(2'(i), 2'(3 - i), i[0], 1'b1);
            chk(lift8, lx[i]);
            chk(receive_sensitivity_out, sx[i]);
            chk(st8, 8'h03);
            r(8'h03);
            chk(v, 8'h01);
            r(8'h0E);
            chk(v, lx[i]);
            chk({7'h0, ok}, 8'h01);
        end
    endtask

    task automatic t_rw();
        r(8'h03);
        w(8'h03, {v[7:1], 1'b1});
        r(8'h0E);
        w(8'h0E, {v[7:4], 4'hF});
        chk(lift8, 8'h0F);
        w(8'h25, 8'hFF);
        chk(receive_sensitivity_out, 8'hFF);
        r(8'h25);
        chk(v, 8'hFF);
        w(8'h03, 8'h00);
        chk(st8, 8'h02);
        w(8'h03, 8'h01);
        chk(st8, 8'h03);
    endtask

    task automatic t_unmapped();
        w(8'h0F, 8'hA5);
        chk(lift8, 8'h0F);
        chk(receive_sensitivity_out, 8'hFF);
        r(8'h0F);
        chk(v, 8'h00);
    endtask

    // Burst from an empty offset: first byte is dropped, the pointer moves on to sensitivity
    task automatic t_burst();
        logic [7:0] r;
        logic       k1, k2, k3, k4;
        i_scs_i2c_host.ph(1'b1, 1'b0);
        i_scs_i2c_host.xb(8'h58, r, k1);
        i_scs_i2c_host.xb(8'h24, r, k2);
        i_scs_i2c_host.xb(8'h12, r, k3);
        i_scs_i2c_host.xb(8'h3C, r, k4);
        i_scs_i2c_host.ph(1'b0, 1'b0);
        i_scs_i2c_host.ph(1'b1, 1'b1);
        chk({4'h0, k1, k2, k3, k4}, 8'h0F);
        chk(receive_sensitivity_out, 8'h3C);
        chk(lift8, 8'h0F);
    endtask

    // Foreign target address, or a frozen clock enable, must leave the bank alone
    task automatic t_ignored(input logic [6:0] a, input logic c);
        ce_in <= c;
        i_scs_i2c_host.wr(a, 8'h0E, 8'h05, ok);
        ce_in <= 1'b1;
        chk({7'h0, ok}, 8'h00);
        chk(lift8, 8'h0F);
    endtask

    task automatic t_late();
        @(posedge mclk_in);
        boost_level_in <= 2'h3;
        repeat (8) @(posedge mclk_in);
        chk(lift8, 8'h0F);
        do_rst(2'h3, 2'h2, 1'b1, 1'b1);
        chk(lift8, 8'h06);
    endtask

    task automatic t_dead();
        do_rst(2'h0, 2'h0, 1'b0, 1'b0);
        chk(st8, 8'h00);
        w(8'h25, 8'h11);
        chk({7'h0, ok}, 8'h00);
        chk(receive_sensitivity_out, 8'h00);
    endtask

    initial begin
        do_rst(2'h1, 2'h1, 1'b0, 1'b1);
        t_straps();
        t_rw();
        t_unmapped();
        t_burst();
        t_ignored(7'h2D, 1'b1);
        t_ignored(7'h2C, 1'b0);
        t_late();
        t_dead();
        results();
    end
endmodule
`default_nettype wire
